// ---- spc_pkg.sv ----
// constants, offsets and types shared by the common-command block
package spc_pkg;
	localparam int          ADDR_W        = 8;
	localparam int          DATA_W        = 32;
	localparam int          STRB_W        = 4;
	localparam int          BYTE_W        = 8;
	localparam logic [7:0]  OFF_CMD       = 8'h00;
	localparam logic [7:0]  OFF_ESR       = 8'h04;
	localparam logic [7:0]  OFF_OUTQ      = 8'h08;
	localparam logic [7:0]  OFF_PRE       = 8'h0c;
	localparam logic [7:0]  OFF_STAT      = 8'h10;
	localparam logic [7:0]  OFF_INTST     = 8'h14;
	localparam logic [7:0]  OFF_INTMSK    = 8'h18;
	localparam logic [7:0]  OFF_LRNIN     = 8'h1c;
	localparam logic [7:0]  OFF_SETUP     = 8'h20;
	localparam int          CMD_OP_LSB    = 0;
	localparam int          CMD_ARG_LSB   = 8;
	localparam int          ARG_W         = 16;
	localparam logic [15:0] PRE_MAX       = 16'h00ff;
	localparam logic [7:0]  OP_IST_Q      = 8'h01;
	localparam logic [7:0]  OP_LRN_Q      = 8'h02;
	localparam logic [7:0]  OP_OPC        = 8'h03;
	localparam logic [7:0]  OP_OPC_Q      = 8'h04;
	localparam logic [7:0]  OP_PRE        = 8'h05;
	localparam logic [7:0]  OP_PRE_Q      = 8'h06;
	localparam logic [7:0]  OP_CLS        = 8'h07;
	localparam logic [7:0]  OP_ESR_Q      = 8'h08;
	localparam int          ESR_OPC       = 0;
	localparam int          ESR_QYE       = 2;
	localparam int          ESR_EXE       = 4;
	localparam int          ESR_CME       = 5;
	localparam int          OUTQ_VALID    = 8;
	localparam int          OUTQ_EOI      = 9;
	localparam int          STAT_IST      = 0;
	localparam int          STAT_BUSY     = 1;
	localparam int          STAT_STB_LSB  = 8;
	localparam int          INT_RESP      = 0;
	localparam int          INT_OPC       = 1;
	localparam int          INT_ERR       = 2;
	localparam int          INT_W         = 3;
	localparam int          SETUP_IDX_LSB = 8;
	localparam int          SETUP_AW      = 4;
	localparam int          IDX_W         = 5;
	localparam logic [4:0]  SETUP_BYTES   = 5'h10;
	localparam logic [4:0]  SETUP_LAST    = 5'h0f;
	localparam logic [10:0] LRN_MAX_BYTES = 11'h7d0;
	localparam logic [7:0]  CH_0          = 8'h30;
	localparam logic [7:0]  CH_1          = 8'h31;
	localparam logic [7:0]  CH_LF         = 8'h0a;
	localparam logic [7:0]  DEC_HUND      = 8'h64;
	localparam logic [7:0]  DEC_TEN       = 8'h0a;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
	typedef enum logic [1:0] {ST_IDLE, ST_EMIT, ST_LEARN, ST_LEARN_END} spc_state_t;
endpackage

// ---- spc_sync.sv ----
// two-flop synchroniser for the status byte pins
`timescale 1ns/1ps
`default_nettype none
module spc_sync import spc_pkg::*; (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic [BYTE_W-1:0] asyncIn,
	output var  logic [BYTE_W-1:0] syncOut
);
	logic [BYTE_W-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			meta_q  <= '0;
			syncOut <= '0;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end
endmodule // spc_sync
`default_nettype wire

// ---- spc_setup_mem.sv ----
// instrument setup memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module spc_setup_mem import spc_pkg::*; (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                wrEn,
	input  wire logic [SETUP_AW-1:0] wrAddr,
	input  wire logic [BYTE_W-1:0]   wrData,
	input  wire logic [SETUP_AW-1:0] rdAddr,
	output var  logic [BYTE_W-1:0]   rdData
);
	logic [BYTE_W-1:0] mem [0:(1<<SETUP_AW)-1];

	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rdData <= '0;
		end else begin
			rdData <= mem[rdAddr];
		end
	end
endmodule // spc_setup_mem
`default_nettype wire

// ---- spc_common_cmd.sv ----
// common-command interpreter: ist, learn, operation complete, parallel poll enable
`timescale 1ns/1ps
`default_nettype none
// Function
// RULE1 - individual status query returns current ist value, no parallel poll performed
// RULE2 - learn query answers with a message holding the full instrument setup
// RULE3 - learn response is always shorter than 2000 bytes
// RULE4 - final line feed of a response carries EOI; controller ends only on that
// RULE5 - a learn string written back restores the setup it describes
// RULE6 - operation complete command sets the OPC bit once nothing is pending
// RULE7 - nothing stays pending; each command finishes before the next starts
// RULE8 - operation complete query queues ASCII 1 once nothing is pending
// RULE9 - parallel poll enable loads an 8-bit mask; controller sends 0 to 255
// RULE10 - ist is 1 when any status bit and its enable bit are both set
// RULE11 - parallel poll enable query returns the stored mask
// RULE12 - OPC flag lives in bit 0 of the event status register
// RULE13 - event status register clears on clear-status and after its own query
// RULE14 - out-of-range mask is rejected, mask kept, execution error flagged
module spc_common_cmd import spc_pkg::*; (
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output var  logic              awready,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic [STRB_W-1:0] wstrb,
	input  wire logic              wvalid,
	output var  logic              wready,
	output var  logic [1:0]        bresp,
	output var  logic              bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output var  logic              arready,
	output var  logic [DATA_W-1:0] rdata,
	output var  logic [1:0]        rresp,
	output var  logic              rvalid,
	input  wire logic              rready,
	input  wire logic [BYTE_W-1:0] statusByte,
	output var  logic              ist,
	output var  logic              irq
);
	function automatic logic [DATA_W-1:0] strbMask(input logic [STRB_W-1:0] s);
		logic [DATA_W-1:0] m;
		m = '0;
		for (int i = 0; i < STRB_W; i++) begin
			m[i*BYTE_W +: BYTE_W] = {BYTE_W{s[i]}};
		end
		return m;
	endfunction

	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		return a == OFF_CMD || a == OFF_ESR || a == OFF_OUTQ || a == OFF_PRE || a == OFF_STAT ||
			a == OFF_INTST || a == OFF_INTMSK || a == OFF_LRNIN || a == OFF_SETUP;
	endfunction

	// returns {length, bytes low first}; decimal digits then line feed
	function automatic logic [34:0] decimalResp(input logic [7:0] v);
		logic [7:0] h;
		logic [7:0] t;
		logic [7:0] o;
		h = v / DEC_HUND;
		t = (v / DEC_TEN) % DEC_TEN;
		o = v % DEC_TEN;
		if (h != '0) begin
			return {3'h4, CH_LF, CH_0 + o, CH_0 + t, CH_0 + h};
		end else if (t != '0) begin
			return {3'h3, 8'h00, CH_LF, CH_0 + o, CH_0 + t};
		end else begin
			return {3'h2, 16'h0000, CH_LF, CH_0 + o};
		end
	endfunction

	logic [ADDR_W-1:0]   awAddr_q;
	logic [DATA_W-1:0]   wData_q;
	logic [STRB_W-1:0]   wStrb_q;
	logic                awHeld_q;
	logic                wHeld_q;
	logic [7:0]          esr_q;
	logic [7:0]          pre_q;
	logic [INT_W-1:0]    intSt_q;
	logic [INT_W-1:0]    intMask_q;
	spc_state_t          state_q;
	logic [31:0]         respBytes_q;
	logic [2:0]          respLen_q;
	logic [2:0]          respIdx_q;
	logic [IDX_W-1:0]    lrnIdx_q;
	logic [IDX_W-1:0]    restIdx_q;
	logic [BYTE_W-1:0]   outqByte_q;
	logic                outqValid_q;
	logic                outqEoi_q;
	logic [10:0]         lrnCount_q;
	logic [BYTE_W-1:0]   stbSync;
	logic [BYTE_W-1:0]   memRdata;
	logic [DATA_W-1:0]   wrData;
	logic [DATA_W-1:0]   rdMux;
	logic [7:0]          cmdOp;
	logic [ARG_W-1:0]    cmdArg;
	logic [7:0]          esrSet;
	logic [INT_W-1:0]    intSet;
	logic                wrGo;
	logic                wrCmd;
	logic                cmdGo;
	logic                cmdBusy;
	logic                rdGo;
	logic                outqPop;
	logic                loadNow;
	logic                istRaw;
	logic                memWe;
	logic [SETUP_AW-1:0] memWaddr;
	logic [BYTE_W-1:0]   memWdata;

	spc_sync u_sync (
		.clk     (clk),
		.reset   (reset),
		.asyncIn (statusByte),
		.syncOut (stbSync)
	);

	spc_setup_mem u_mem (
		.clk    (clk),
		.reset  (reset),
		.wrEn   (memWe),
		.wrAddr (memWaddr),
		.wrData (memWdata),
		.rdAddr (lrnIdx_q[SETUP_AW-1:0]),
		.rdData (memRdata)
	);

	assign wrGo    = awHeld_q & wHeld_q & ~bvalid;
	assign wrData  = wData_q & strbMask(wStrb_q);
	assign wrCmd   = wrGo & (awAddr_q == OFF_CMD);
	assign cmdOp   = wrData[CMD_OP_LSB +: 8];
	assign cmdArg  = wrData[CMD_ARG_LSB +: ARG_W];
	assign cmdGo   = wrCmd & (state_q == ST_IDLE); // RULE7
	assign cmdBusy = wrCmd & (state_q != ST_IDLE);
	assign rdGo    = arvalid & arready;
	assign outqPop = rdGo & (araddr == OFF_OUTQ) & outqValid_q;
	assign loadNow = (state_q != ST_IDLE) & ~outqValid_q;
	assign istRaw  = |(stbSync & pre_q); // RULE10

	// setup writes and learn-string restore share the one write port
	always_comb begin
		memWe    = 1'b0;
		memWaddr = restIdx_q[SETUP_AW-1:0];
		memWdata = wrData[BYTE_W-1:0];
		if (wrGo && awAddr_q == OFF_SETUP) begin
			memWe    = 1'b1;
			memWaddr = wrData[SETUP_IDX_LSB +: SETUP_AW];
		end else if (wrGo && awAddr_q == OFF_LRNIN && restIdx_q < SETUP_BYTES) begin
			memWe    = 1'b1; // RULE5
		end
	end

	// restore accepts setup bytes in order; the next byte is the terminator
	always_ff @(posedge clk) begin
		if (reset) begin
			restIdx_q <= '0;
		end else if (wrGo && awAddr_q == OFF_LRNIN) begin
			restIdx_q <= (restIdx_q < SETUP_BYTES) ? restIdx_q + 5'h01 : '0; // RULE5
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			awready  <= 1'b1;
			wready   <= 1'b1;
			awHeld_q <= 1'b0;
			wHeld_q  <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= RESP_OKAY;
			awAddr_q <= '0;
			wData_q  <= '0;
			wStrb_q  <= '0;
		end else begin
			if (awvalid && awready) begin
				awAddr_q <= awaddr;
				awHeld_q <= 1'b1;
				awready  <= 1'b0;
			end
			if (wvalid && wready) begin
				wData_q <= wdata;
				wStrb_q <= wstrb;
				wHeld_q <= 1'b1;
				wready  <= 1'b0;
			end
			if (wrGo) begin
				bvalid   <= 1'b1;
				bresp    <= isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
				awHeld_q <= 1'b0;
				wHeld_q  <= 1'b0;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_comb begin
		rdMux = '0;
		case (araddr)
			OFF_ESR:    rdMux[7:0] = esr_q;
			OFF_OUTQ:   rdMux[OUTQ_EOI:0] = {outqEoi_q, outqValid_q, outqByte_q};
			OFF_PRE:    rdMux[7:0] = pre_q; // RULE11
			OFF_STAT:   begin
				rdMux[STAT_IST]                  = ist;
				rdMux[STAT_BUSY]                 = state_q != ST_IDLE;
				rdMux[STAT_STB_LSB +: BYTE_W]    = stbSync;
			end
			OFF_INTST:  rdMux[INT_W-1:0] = intSt_q;
			OFF_INTMSK: rdMux[INT_W-1:0] = intMask_q;
			default:    rdMux = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else begin
			if (rdGo) begin
				arready <= 1'b0;
				rvalid  <= 1'b1;
				rdata   <= rdMux;
				rresp   <= isMapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			end
			if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end

	// no pending operations exist, so opc is set in the same cycle as the command
	always_comb begin
		esrSet          = '0;
		esrSet[ESR_OPC] = cmdGo & (cmdOp == OP_OPC); // RULE6 RULE12
		esrSet[ESR_EXE] = cmdGo & (cmdOp == OP_PRE) & (cmdArg > PRE_MAX); // RULE14
		esrSet[ESR_QYE] = cmdBusy;
		esrSet[ESR_CME] = cmdGo & (cmdOp == '0 || cmdOp > OP_ESR_Q);
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			esr_q <= '0;
		end else if (cmdGo && (cmdOp == OP_CLS || cmdOp == OP_ESR_Q)) begin
			esr_q <= esrSet; // RULE13
		end else begin
			esr_q <= esr_q | esrSet;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pre_q <= '0;
		end else if (cmdGo && cmdOp == OP_PRE && cmdArg <= PRE_MAX) begin
			pre_q <= cmdArg[7:0]; // RULE9 RULE14
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ist <= 1'b0;
		end else begin
			ist <= istRaw; // RULE10
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_q     <= ST_IDLE;
			respBytes_q <= '0;
			respLen_q   <= '0;
			respIdx_q   <= '0;
			lrnIdx_q    <= '0;
			outqByte_q  <= '0;
			outqValid_q <= 1'b0;
			outqEoi_q   <= 1'b0;
		end else begin
			if (outqPop) begin
				outqValid_q <= 1'b0;
			end
			case (state_q)
				ST_IDLE: begin
					respIdx_q <= '0;
					if (cmdGo) begin
						case (cmdOp)
							OP_IST_Q: begin
								respBytes_q <= {16'h0000, CH_LF, CH_0 + {7'h00, ist}}; // RULE1
								respLen_q   <= 3'h2;
								state_q     <= ST_EMIT;
							end
							OP_OPC_Q: begin
								respBytes_q <= {16'h0000, CH_LF, CH_1}; // RULE8
								respLen_q   <= 3'h2;
								state_q     <= ST_EMIT;
							end
							OP_PRE_Q: begin
								{respLen_q, respBytes_q} <= decimalResp(pre_q); // RULE11
								state_q                  <= ST_EMIT;
							end
							OP_ESR_Q: begin
								{respLen_q, respBytes_q} <= decimalResp(esr_q);
								state_q                  <= ST_EMIT;
							end
							OP_LRN_Q: state_q <= ST_LEARN; // RULE2
							default:  state_q <= ST_IDLE;
						endcase
					end
				end
				ST_EMIT: if (loadNow) begin
					outqByte_q  <= respBytes_q[{respIdx_q[1:0], 3'h0} +: BYTE_W];
					outqEoi_q   <= respIdx_q == respLen_q - 3'h1; // RULE4
					outqValid_q <= 1'b1;
					respIdx_q   <= respIdx_q + 3'h1;
					if (respIdx_q == respLen_q - 3'h1) begin
						state_q <= ST_IDLE;
					end
				end
				// binary setup bytes may equal line feed; only the trailer carries eoi
				ST_LEARN: if (loadNow) begin
					outqByte_q  <= memRdata; // RULE2
					outqEoi_q   <= 1'b0;
					outqValid_q <= 1'b1;
					lrnIdx_q    <= lrnIdx_q + 5'h01;
					if (lrnIdx_q == SETUP_LAST) begin
						state_q <= ST_LEARN_END;
					end
				end
				ST_LEARN_END: if (loadNow) begin
					outqByte_q  <= CH_LF;
					outqEoi_q   <= 1'b1; // RULE4
					outqValid_q <= 1'b1;
					lrnIdx_q    <= '0;
					state_q     <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always_comb begin
		intSet           = '0;
		intSet[INT_RESP] = loadNow;
		intSet[INT_OPC]  = esrSet[ESR_OPC];
		intSet[INT_ERR]  = esrSet[ESR_QYE] | esrSet[ESR_EXE] | esrSet[ESR_CME];
	end

	// write-one-to-clear; a new event in the same cycle survives the clear
	always_ff @(posedge clk) begin
		if (reset) begin
			intSt_q   <= '0;
			intMask_q <= '0;
			irq       <= 1'b0;
		end else begin
			if (wrGo && awAddr_q == OFF_INTST) begin
				intSt_q <= (intSt_q & ~wrData[INT_W-1:0]) | intSet;
			end else begin
				intSt_q <= intSt_q | intSet;
			end
			if (wrGo && awAddr_q == OFF_INTMSK) begin
				intMask_q <= wrData[INT_W-1:0];
			end
			irq <= |(intSt_q & intMask_q);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			lrnCount_q <= '0;
		end else if (cmdGo && cmdOp == OP_LRN_Q) begin
			lrnCount_q <= '0;
		end else if (loadNow && state_q != ST_EMIT) begin
			lrnCount_q <= lrnCount_q + 11'h001; // RULE3
		end
	end

	property p_ist_follow;
		@(posedge clk) disable iff (reset) 1'b1 |=> ist == $past(|(stbSync & pre_q));
	endproperty
	a_ist_follow: assert property (p_ist_follow) else $error("ist not equal to enabled status"); // RULE10

	property p_pre_load;
		@(posedge clk) disable iff (reset) (cmdGo && cmdOp == OP_PRE && cmdArg <= PRE_MAX) |=> pre_q == $past(cmdArg[7:0]);
	endproperty
	a_pre_load: assert property (p_pre_load) else $error("mask not loaded"); // RULE9

	property p_pre_reject;
		@(posedge clk) disable iff (reset) (cmdGo && cmdOp == OP_PRE && cmdArg > PRE_MAX) |=> $stable(pre_q) && esr_q[ESR_EXE];
	endproperty
	a_pre_reject: assert property (p_pre_reject) else $error("bad mask not rejected"); // RULE14

	property p_opc_set;
		@(posedge clk) disable iff (reset) (cmdGo && cmdOp == OP_OPC) |=> esr_q[ESR_OPC];
	endproperty
	a_opc_set: assert property (p_opc_set) else $error("opc bit not set"); // RULE6

	property p_cls;
		@(posedge clk) disable iff (reset) (cmdGo && cmdOp == OP_CLS) |=> esr_q == 8'h00;
	endproperty
	a_cls: assert property (p_cls) else $error("event status not cleared"); // RULE13

	property p_opcq;
		@(posedge clk) disable iff (reset) (cmdGo && cmdOp == OP_OPC_Q && !outqValid_q) |-> ##2 outqValid_q && outqByte_q == CH_1;
	endproperty
	a_opcq: assert property (p_opcq) else $error("opc query answer missing"); // RULE8

	property p_istq;
		@(posedge clk) disable iff (reset) (cmdGo && cmdOp == OP_IST_Q && !outqValid_q) |-> ##2 outqByte_q == CH_0 + {7'h00, $past(ist, 2)};
	endproperty
	a_istq: assert property (p_istq) else $error("ist query answer wrong"); // RULE1

	property p_eoi_lf;
		@(posedge clk) disable iff (reset) (outqValid_q && outqEoi_q) |-> outqByte_q == CH_LF;
	endproperty
	a_eoi_lf: assert property (p_eoi_lf) else $error("eoi on a byte other than line feed"); // RULE4

	property p_lrn_len;
		@(posedge clk) disable iff (reset) lrnCount_q < LRN_MAX_BYTES;
	endproperty
	a_lrn_len: assert property (p_lrn_len) else $error("learn response too long"); // RULE3

	property p_busy;
		@(posedge clk) disable iff (reset) cmdBusy |=> esr_q[ESR_QYE] && $stable(pre_q);
	endproperty
	a_busy: assert property (p_busy) else $error("overlapping command not flagged"); // RULE7
endmodule // spc_common_cmd
`default_nettype wire

// ---- spc_bus_master.sv ----
// register-bus master model standing in for the remote controller
`timescale 1ns/1ps
`default_nettype none
module spc_bus_master import spc_pkg::*; (
	input  wire logic              clk,
	output var  logic [ADDR_W-1:0] awaddr,
	output var  logic              awvalid,
	input  wire logic              awready,
	output var  logic [DATA_W-1:0] wdata,
	output var  logic [STRB_W-1:0] wstrb,
	output var  logic              wvalid,
	input  wire logic              wready,
	input  wire logic [1:0]        bresp,
	input  wire logic              bvalid,
	output var  logic              bready,
	output var  logic [ADDR_W-1:0] araddr,
	output var  logic              arvalid,
	input  wire logic              arready,
	input  wire logic [DATA_W-1:0] rdata,
	input  wire logic [1:0]        rresp,
	input  wire logic              rvalid,
	output var  logic              rready
);
	// answers are held back this many cycles to play a slow controller
	int slowCycles = 0;
	initial begin
		awaddr = '0;
		awvalid = 1'b0;
		wdata = '0;
		wstrb = '0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
	end
	task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, output logic [1:0] resp);
		@(posedge clk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= 4'hf;
		wvalid  <= 1'b1;
		@(posedge clk);
		while (awvalid || wvalid) begin
			// released lines show garbage, not the last value
			if (awvalid && awready) begin
				awvalid <= 1'b0;
				awaddr  <= ~a;
			end
			if (wvalid && wready) begin
				wvalid <= 1'b0;
				wdata  <= ~d;
			end
			@(posedge clk);
		end
		repeat (slowCycles) @(posedge clk);
		bready <= 1'b1;
		@(posedge clk);
		while (!bvalid) @(posedge clk);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic [1:0] resp);
		@(posedge clk);
		araddr  <= a;
		arvalid <= 1'b1;
		@(posedge clk);
		while (!arready) @(posedge clk);
		arvalid <= 1'b0;
		araddr  <= ~a;
		repeat (slowCycles) @(posedge clk);
		rready <= 1'b1;
		@(posedge clk);
		while (!rvalid) @(posedge clk);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
endmodule // spc_bus_master
`default_nettype wire

// ---- spc_common_cmd_tb_top.sv ----
// self-checking bench for the common-command interpreter
`timescale 1ns/1ps
`default_nettype none
module spc_common_cmd_tb_top import spc_pkg::*; ;
	typedef logic [7:0] spc_bytes_t [$];
	logic              clk = 1'b0;
	logic              reset = 1'b1;
	logic [BYTE_W-1:0] statusByte = '0;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [DATA_W-1:0] wdata, rdata;
	logic [STRB_W-1:0] wstrb;
	logic [1:0]        bresp, rresp;
	logic              awvalid, awready, wvalid, wready, bvalid, bready;
	logic              arvalid, arready, rvalid, rready, ist, irq;
	logic [7:0]        masks [4] = '{8'h00, 8'hff, 8'h01, 8'h10};
	int                err_total = 0;
	int                n_checks = 0;
	always #5 clk = ~clk;
	spc_common_cmd uut (.clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .statusByte(statusByte), .ist(ist), .irq(irq));
	spc_bus_master bm (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));
	task automatic complete_run();
		$display("checks %0d, mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic chkMsg(input string what, input spc_bytes_t exp, input spc_bytes_t got);
		logic bad;
		bad = (got.size() != exp.size());
		foreach (exp[i]) if (!bad && got[i] !== exp[i]) bad = 1'b1;
		n_checks++;
		if (bad) begin
			err_total++;
			$display("unexpected %s: expected %p, seen %p", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		bm.write(a, d, r);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic [1:0] r;
		bm.read(a, d, r);
		chk("rresp", {30'h0, RESP_OKAY}, {30'h0, r});
	endtask
	task automatic cmd(input logic [7:0] op, input logic [15:0] arg);
		wr(OFF_CMD, {8'h00, arg, op});
	endtask
	// drains the output queue; binary bytes may be line feeds, only LF with eoi ends it
	task automatic getMsg(output spc_bytes_t q);
		logic [31:0] d;
		q = {};
		for (int i = 0; i < 3000; i++) begin
			rd(OFF_OUTQ, d);
			if (d[OUTQ_VALID] === 1'b1) q.push_back(d[7:0]);
			if (d[OUTQ_VALID] === 1'b1 && d[OUTQ_EOI] === 1'b1 && d[7:0] === CH_LF) break;
		end
	endtask
	function automatic spc_bytes_t asText(input int v);
		spc_bytes_t q;
		q = {CH_LF};
		do begin
			q.push_front(8'(CH_0 + v % 10));
			v = v / 10;
		end while (v > 0);
		return q;
	endfunction
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		complete_run();
	end
	initial begin
		spc_bytes_t msg;
		spc_bytes_t lrn;
		logic [31:0] d;
		logic [1:0]  r;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd(OFF_ESR, d);
		chk("esr", 32'h0, d);
		rd(OFF_PRE, d);
		chk("pre", 32'h0, d);
		chk("ist pin", 32'h0, {31'h0, ist});
		$display("test reset done");
		foreach (masks[i]) begin
			cmd(OP_PRE, {8'h00, masks[i]});
			rd(OFF_PRE, d);
			chk("pre", 32'(masks[i]), d);
			cmd(OP_PRE_Q, 16'h0);
			getMsg(msg);
			chkMsg("pre query", asText(int'(masks[i])), msg);
		end
		cmd(OP_PRE, 16'h0100);
		cmd(OP_PRE, 16'hffff);
		rd(OFF_PRE, d);
		chk("pre kept", 32'h10, d);
		rd(OFF_ESR, d);
		chk("esr exe", 32'(1 << ESR_EXE), d);
		cmd(OP_CLS, 16'h0);
		rd(OFF_ESR, d);
		chk("esr cls", 32'h0, d);
		cmd(8'h09, 16'h0);
		rd(OFF_ESR, d);
		chk("esr cme", 32'(1 << ESR_CME), d);
		cmd(OP_CLS, 16'h0);
		$display("test parallel poll enable done");
		@(posedge clk);
		statusByte <= 8'h10;
		repeat (4) @(posedge clk);
		chk("ist pin", 32'h1, {31'h0, ist});
		rd(OFF_STAT, d);
		chk("stat ist", 32'h1, {31'h0, d[STAT_IST]});
		chk("stat stb", 32'h10, {24'h0, d[STAT_STB_LSB +: BYTE_W]});
		cmd(OP_IST_Q, 16'h0);
		getMsg(msg);
		chkMsg("ist query", asText(1), msg);
		@(posedge clk);
		statusByte <= 8'hef;
		repeat (4) @(posedge clk);
		chk("ist pin", 32'h0, {31'h0, ist});
		cmd(OP_IST_Q, 16'h0);
		rd(OFF_STAT, d);
		chk("stat busy", 32'h1, {31'h0, d[STAT_BUSY]});
		cmd(OP_OPC, 16'h0);
		rd(OFF_ESR, d);
		chk("busy refusal", 32'(1 << ESR_QYE), d);
		getMsg(msg);
		chkMsg("ist query", asText(0), msg);
		cmd(OP_CLS, 16'h0);
		$display("test individual status done");
		cmd(OP_OPC, 16'h0);
		rd(OFF_ESR, d);
		chk("esr opc", 32'h1, d);
		cmd(OP_ESR_Q, 16'h0);
		getMsg(msg);
		chkMsg("esr query", asText(1), msg);
		rd(OFF_ESR, d);
		chk("esr after query", 32'h0, d);
		cmd(OP_OPC_Q, 16'h0);
		getMsg(msg);
		chkMsg("opc query", asText(1), msg);
		$display("test operation complete done");
		lrn = {};
		for (int i = 0; i < 16; i++) begin
			wr(OFF_SETUP, (32'(i) << SETUP_IDX_LSB) | 32'(8'(i) ^ CH_LF));
			lrn.push_back(8'(i) ^ CH_LF);
		end
		lrn.push_back(CH_LF);
		cmd(OP_LRN_Q, 16'h0);
		getMsg(msg);
		chkMsg("learn", lrn, msg);
		chk("learn short", 32'h1, {31'h0, msg.size() < 2000});
		bm.slowCycles = 3;
		lrn = {};
		for (int i = 0; i < 16; i++) lrn.push_back(8'(i * 16) + CH_LF);
		lrn.push_back(CH_LF);
		foreach (lrn[i]) wr(OFF_LRNIN, 32'(lrn[i]));
		cmd(OP_LRN_Q, 16'h0);
		getMsg(msg);
		chkMsg("restored learn", lrn, msg);
		bm.slowCycles = 0;
		$display("test learn done");
		rd(OFF_INTST, d);
		chk("intst", 32'h7, d);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(OFF_INTMSK, 32'(1 << INT_RESP));
		repeat (2) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(OFF_INTST, 32'h7);
		repeat (2) @(posedge clk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		rd(OFF_INTST, d);
		chk("intst cleared", 32'h0, d);
		bm.write(8'h40, 32'h1, r);
		chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		bm.read(8'h40, d, r);
		chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
		chk("unmapped rdata", 32'h0, d);
		$display("test interrupts done");
		complete_run();
	end
endmodule // spc_common_cmd_tb_top
`default_nettype wire
